// *** rtl/cpu_register_core.v ***
// CPU state block: fetch pointer, flag word, stack pointer,
// banked general registers and data memory map decode.
// Assumes an execution unit on the same clock drives the op strobes.
`timescale 1ns/10ps
`include "cpu_core_map.vh"

module cpu_register_core (
    // Clock and reset
    input wire clock,
    input wire sys_rst,
    // Fetch pointer control
    input wire fetch_adv,
    input wire [2:0] fetch_len,
    input wire branch_load,
    input wire [15:0] branch_target,
    // Flag word control
    input wire irq_ack,
    input wire flag_word_save_op,
    input wire flag_word_restore_op,
    input wire break_return_op,
    input wire irq_return_op,
    input wire [7:0] flag_word_pop_data,
    input wire irq_block_op,
    input wire irq_unblock_op,
    input wire bank_choose_op,
    input wire [1:0] bank_choose_val,
    input wire isp_load,
    input wire isp_val,
    input wire alu_update,
    input wire [7:0] alu_result,
    input wire alu_nib_carry,
    input wire carry_load,
    input wire carry_val,
    // Interrupt acceptance
    input wire irq_req_maskable,
    input wire irq_req_low_prio,
    // Stack pointer control
    input wire sp_load,
    input wire [15:0] sp_load_val,
    input wire sp_push,
    input wire sp_pop,
    // General registers
    input wire [2:0] greg_rd_sel,
    input wire [1:0] greg_pair_sel,
    input wire greg_wr,
    input wire greg_wr_pair,
    input wire [2:0] greg_wr_sel,
    input wire [15:0] greg_wr_data,
    // Data memory access
    input wire mem_req,
    input wire mem_wr,
    input wire mem_word,
    input wire mem_fetch,
    input wire [15:0] mem_addr,
    input wire [7:0] mem_wdata,
    input wire [7:0] boot_rdata,
    // Outputs
    output reg [15:0] next_fetch_pointer,
    output reg [7:0] processor_flag_word,
    output reg [15:0] stack_top_pointer,
    output reg [7:0] greg_rd_byte,
    output reg [15:0] greg_rd_pair,
    output reg [2:0] mem_region,
    output reg [7:0] mem_rdata,
    output reg [15:0] boot_addr,
    output reg boot_busy,
    output reg irq_accept,
    output reg sp_range_err,
    output reg mem_fault
);

// ------------------------------------------------------------------
// Decoding helpers
// ------------------------------------------------------------------
function [2:0] region_of;
    input [15:0] a;
    begin
        if (a >= `GREG_BASE && a <= `HSRAM_LAST)
            region_of = `RGN_GREG;
        else if (a >= `HSRAM_BASE && a <= `HSRAM_LAST)
            region_of = `RGN_HSRAM;
        else if (a >= `XRAM_BASE && a <= `XRAM_LAST)
            region_of = `RGN_XRAM;
        else if (a >= `DRAM_BASE && a <= `DRAM_LAST)
            region_of = `RGN_DRAM;
        else if (a >= `SFR_BASE)
            region_of = `RGN_SFR;
        else
            region_of = `RGN_NONE;
    end
endfunction

function in_stack_range;
    input [15:0] a;
    begin
        in_stack_range = (a >= `HSRAM_BASE) && (a <= `HSRAM_LAST);
    end
endfunction

// ------------------------------------------------------------------
// Storage
// ------------------------------------------------------------------
reg [7:0] greg_mem [0:31];
reg [7:0] hsram_mem [0:991];
reg [7:0] xram_mem [0:1023];
reg [2:0] dram_mem [0:`DRAM_DEPTH-1];
localparam [`BOOT_W-1:0] BOOT_VEC_LO = `BOOT_LO;
localparam [`BOOT_W-1:0] BOOT_VEC_HI = `BOOT_HI;
localparam [`BOOT_W-1:0] BOOT_DONE = `BOOT_RUN;
reg [`BOOT_W-1:0] boot_r;
reg [7:0] vec_lo_r;

wire [1:0] bank = {processor_flag_word[`FW_BSH],
    processor_flag_word[`FW_BSL]};
wire [2:0] rgn = region_of(mem_addr);
wire [15:0] hs_off = mem_addr - `HSRAM_BASE;
wire [15:0] xr_off = mem_addr - `XRAM_BASE;
wire [15:0] dr_off = mem_addr - `DRAM_BASE;
wire [4:0] gr_abs = mem_addr[`GREG_IDX_W-1:0];
wire [4:0] rd_idx = {bank, greg_rd_sel};
wire [4:0] pr_lo = {bank, greg_pair_sel, 1'b0};
wire [4:0] pr_hi = {bank, greg_pair_sel, 1'b1};
wire [4:0] wr_idx = {bank, greg_wr_sel[2:1],
    greg_wr_sel[0] & ~greg_wr_pair};
wire dr_ok = dr_off[4:0] < `DRAM_DEPTH;
wire [15:0] sp_dec = stack_top_pointer - `ONE16;
wire [15:0] sp_inc = stack_top_pointer + `ONE16;

// ------------------------------------------------------------------
// Fetch pointer and reset vector load
// ------------------------------------------------------------------
always @(posedge clock) begin
    if (sys_rst) begin
        boot_r <= BOOT_VEC_LO;
        boot_busy <= 1'b1;
        boot_addr <= `RESET_VEC_LO;
        vec_lo_r <= 8'h00;
        next_fetch_pointer <= 16'h0000;
    end else begin
        case (boot_r)
        BOOT_VEC_LO: begin
            vec_lo_r <= boot_rdata;
            boot_addr <= `RESET_VEC_HI;
            boot_r <= BOOT_VEC_HI;
        end
        BOOT_VEC_HI: begin
            next_fetch_pointer <= {boot_rdata, vec_lo_r};
            boot_busy <= 1'b0;
            boot_r <= BOOT_DONE;
        end
        BOOT_DONE: begin
            if (branch_load)
                next_fetch_pointer <= branch_target;
            else if (fetch_adv)
                next_fetch_pointer <= next_fetch_pointer
                    + {13'h0000, fetch_len};
        end
        default: boot_r <= BOOT_DONE;
        endcase
    end
end

// ------------------------------------------------------------------
// Flag word
// ------------------------------------------------------------------
always @(posedge clock) begin
    if (sys_rst) begin
        processor_flag_word <= `FW_RESET;
    end else if (break_return_op || irq_return_op
            || flag_word_restore_op) begin
        processor_flag_word <= flag_word_pop_data;
    end else begin
        if (irq_ack || irq_block_op)
            processor_flag_word[`FW_IE] <= 1'b0;
        else if (irq_unblock_op)
            processor_flag_word[`FW_IE] <= 1'b1;
        if (bank_choose_op) begin
            processor_flag_word[`FW_BSH] <= bank_choose_val[1];
            processor_flag_word[`FW_BSL] <= bank_choose_val[0];
        end
        if (isp_load)
            processor_flag_word[`FW_ISP] <= isp_val;
        if (alu_update) begin
            processor_flag_word[`FW_Z] <= (alu_result == 8'h00);
            processor_flag_word[`FW_AC] <= alu_nib_carry;
        end
        if (carry_load)
            processor_flag_word[`FW_CY] <= carry_val;
    end
end

// ------------------------------------------------------------------
// Interrupt acceptance
// ------------------------------------------------------------------
always @(posedge clock) begin
    if (sys_rst)
        irq_accept <= 1'b0;
    else
        irq_accept <= irq_req_maskable
            && processor_flag_word[`FW_IE]
            && (processor_flag_word[`FW_ISP]
                || !irq_req_low_prio);
end

// ------------------------------------------------------------------
// Stack pointer, no reset value
// ------------------------------------------------------------------
always @(posedge clock) begin
    if (sp_load)
        stack_top_pointer <= sp_load_val;
    else if (sp_push || flag_word_save_op || irq_ack)
        stack_top_pointer <= sp_dec;
    else if (sp_pop)
        stack_top_pointer <= sp_inc;
end

always @(posedge clock) begin
    if (sys_rst)
        sp_range_err <= 1'b0;
    else if (sp_push || sp_pop || flag_word_save_op || irq_ack)
        sp_range_err <= !in_stack_range(sp_push || flag_word_save_op
            || irq_ack ? sp_dec : stack_top_pointer);
end

// ------------------------------------------------------------------
// General registers
// ------------------------------------------------------------------
always @(posedge clock) begin
    if (greg_wr) begin
        greg_mem[wr_idx] <= greg_wr_data[7:0];
        if (greg_wr_pair)
            greg_mem[pr_wr_hi(wr_idx)] <= greg_wr_data[15:8];
    end else if (mem_req && mem_wr && rgn == `RGN_GREG) begin
        greg_mem[gr_abs] <= mem_wdata;
    end
end

function [4:0] pr_wr_hi;
    input [4:0] i;
    begin
        pr_wr_hi = {i[4:1], 1'b1};
    end
endfunction

always @(posedge clock) begin
    greg_rd_byte <= greg_mem[rd_idx];
    greg_rd_pair <= {greg_mem[pr_hi], greg_mem[pr_lo]};
end

// ------------------------------------------------------------------
// Data memories
// ------------------------------------------------------------------
always @(posedge clock) begin
    if (mem_req && mem_wr) begin
        if (rgn == `RGN_HSRAM)
            hsram_mem[hs_off[9:0]] <= mem_wdata;
        if (rgn == `RGN_XRAM)
            xram_mem[xr_off[9:0]] <= mem_wdata;
        if (rgn == `RGN_DRAM && dr_ok)
            dram_mem[dr_off[4:0]] <= mem_wdata[`DRAM_BITS-1:0];
    end
end

always @(posedge clock) begin
    if (sys_rst) begin
        mem_rdata <= 8'h00;
        mem_region <= `RGN_NONE;
        mem_fault <= 1'b0;
    end else if (mem_req) begin
        mem_region <= rgn;
        mem_fault <= (mem_fetch && rgn != `RGN_XRAM
                && rgn != `RGN_NONE)
            || (rgn == `RGN_SFR && mem_word && mem_addr[0])
            || (rgn == `RGN_DRAM && !dr_ok);
        case (rgn)
        `RGN_GREG: mem_rdata <= greg_mem[gr_abs];
        `RGN_HSRAM: mem_rdata <= hsram_mem[hs_off[9:0]];
        `RGN_XRAM: mem_rdata <= xram_mem[xr_off[9:0]];
        `RGN_DRAM: mem_rdata <= dr_ok ?
            {5'h00, dram_mem[dr_off[4:0]]} : 8'h00;
        default: mem_rdata <= 8'h00;
        endcase
    end
end

endmodule

// *** rtl/cpu_core_map.vh ***
// Address map, flag word layout and reset values of the CPU state block.
// Assumes inclusion by the single design file only.
`ifndef CPU_CORE_MAP_VH
`define CPU_CORE_MAP_VH

// ------------------------------------------------------------------
// Data memory regions
// ------------------------------------------------------------------
`define HSRAM_BASE 16'hFB00
`define HSRAM_LAST 16'hFEFF
`define GREG_BASE 16'hFEE0
`define XRAM_BASE 16'hF400
`define XRAM_LAST 16'hF7FF
`define DRAM_BASE 16'hFA00
`define DRAM_LAST 16'hFA10
`define SFR_BASE 16'hFF00
`define SFR_LAST 16'hFFFF
`define RESET_VEC_LO 16'h0000
`define RESET_VEC_HI 16'h0001

// ------------------------------------------------------------------
// Region codes
// ------------------------------------------------------------------
`define RGN_NONE 3'h0
`define RGN_HSRAM 3'h1
`define RGN_GREG 3'h2
`define RGN_XRAM 3'h3
`define RGN_DRAM 3'h4
`define RGN_SFR 3'h5

// ------------------------------------------------------------------
// Flag word layout
// ------------------------------------------------------------------
`define FW_IE 7
`define FW_Z 6
`define FW_BSH 5
`define FW_AC 4
`define FW_BSL 3
`define FW_ISP 1
`define FW_CY 0
`define FW_RESET 8'h02

// ------------------------------------------------------------------
// Widths and steps
// ------------------------------------------------------------------
`define GREG_IDX_W 5
`define DRAM_IDX_W 5
`define DRAM_DEPTH 30
`define DRAM_BITS 3
`define ONE16 16'h0001
`define BOOT_W 2
`define BOOT_LO 2'h0
`define BOOT_HI 2'h1
`define BOOT_RUN 2'h2

`endif

// *** bench/boot_rom_model.sv ***
// Program memory model that holds the reset vector.
// Assumes combinational reads addressed by boot_addr.
`timescale 1ns/10ps
module boot_rom_model #(parameter logic [15:0] VEC = 16'h1234) (
    // Fetch side
    input wire [15:0] boot_addr,
    output logic [7:0] boot_rdata
);
    // Other addresses return a changing pattern
    always_comb begin
        case (boot_addr)
            16'h0000: boot_rdata = VEC[7:0];
            16'h0001: boot_rdata = VEC[15:8];
            default: boot_rdata = ~boot_addr[7:0];
        endcase
    end
endmodule

// *** bench/core_checker.sv ***
// Port checker for the CPU state block.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/10ps
module core_checker (
    // Clock and reset
    input wire clock, sys_rst,
    // Requests
    input wire fetch_adv, branch_load, irq_ack, flag_word_save_op,
    input wire flag_word_restore_op, break_return_op, irq_return_op,
    input wire irq_block_op, sp_load, sp_push, mem_req, mem_fetch,
    input wire irq_req_maskable, irq_req_low_prio,
    input wire [2:0] fetch_len,
    input wire [7:0] flag_word_pop_data, boot_rdata, processor_flag_word,
    input wire [15:0] branch_target, mem_addr, stack_top_pointer,
    // Results
    input wire [15:0] next_fetch_pointer,
    input wire boot_busy, irq_accept, mem_fault
);
    // ----
    // Properties
    // ----
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (sys_rst);
    wire pop = flag_word_restore_op | break_return_op | irq_return_op;
    wire [7:0] fw = processor_flag_word;
    sequence boot_end;
        boot_busy ##1 !boot_busy;
    endsequence
    vec_load_a: assert property (boot_end |->
        next_fetch_pointer == {$past(boot_rdata), $past(boot_rdata, 2)})
        else $error("reset vector not loaded");
    fetch_step_a: assert property (fetch_adv && !branch_load &&
        !boot_busy |=> next_fetch_pointer ==
        $past(next_fetch_pointer) + $past(fetch_len))
        else $error("fetch step wrong");
    branch_jump_a: assert property (branch_load && !boot_busy |=>
        next_fetch_pointer == $past(branch_target))
        else $error("branch target not loaded");
    sp_save_a: assert property (
        (sp_push | flag_word_save_op | irq_ack) && !sp_load |=>
        stack_top_pointer == $past(stack_top_pointer) - 16'h0001)
        else $error("stack pointer not decremented");
    gate_clear_a: assert property ((irq_ack | irq_block_op) && !pop
        |=> !fw[7]) else $error("gate flag not cleared");
    irq_accept_a: assert property (
        !$past(sys_rst) |-> irq_accept ==
        ($past(fw[7]) & $past(irq_req_maskable)
        & ($past(fw[1]) | !$past(irq_req_low_prio))))
        else $error("interrupt acceptance wrong");
    flag_pop_a: assert property (pop |=>
        fw == $past(flag_word_pop_data)) else $error("flag word not restored");
    fetch_fault_a: assert property (mem_req && mem_fetch &&
        mem_addr >= 16'hFB00 && mem_addr <= 16'hFEFF |=> mem_fault)
        else $error("fetch from fast RAM not flagged");
endmodule
bind cpu_register_core core_checker i_chk (.*);

// *** bench/testbench.sv ***
// Self-checking bench for the CPU state block.
// Assumes the program memory model supplies the reset vector.
`timescale 1ns/10ps
module testbench;
    logic clock = 0, sys_rst = 1;
    logic fetch_adv, branch_load, irq_ack, flag_word_save_op, sp_pop;
    logic flag_word_restore_op, break_return_op, irq_return_op, greg_wr;
    logic irq_block_op, irq_unblock_op, bank_choose_op, isp_load, isp_val;
    logic alu_update, alu_nib_carry, carry_load, carry_val, sp_load;
    logic sp_push, greg_wr_pair, mem_req, mem_wr, mem_word, mem_fetch;
    logic irq_req_maskable, irq_req_low_prio, boot_busy, irq_accept;
    logic sp_range_err, mem_fault;
    logic [1:0] bank_choose_val, greg_pair_sel;
    logic [2:0] fetch_len, greg_rd_sel, greg_wr_sel, mem_region;
    logic [7:0] flag_word_pop_data, alu_result, mem_wdata, boot_rdata;
    logic [7:0] processor_flag_word, greg_rd_byte, mem_rdata;
    logic [15:0] branch_target, sp_load_val, greg_wr_data, mem_addr;
    logic [15:0] next_fetch_pointer, stack_top_pointer, greg_rd_pair;
    logic [15:0] boot_addr;
    int errors = 0, tests_run = 0;
    logic [15:0] ra [11] = '{16'hFB00, 16'hFEDF, 16'hFEE0, 16'hFEFF,
        16'hF400, 16'hF7FF, 16'hFA00, 16'hFA10, 16'hFF00, 16'hFFFF, 16'hF3FF};
    logic [2:0] re [11] = '{3'h1, 3'h1, 3'h2, 3'h2, 3'h3, 3'h3, 3'h4, 3'h4,
        3'h5, 3'h5, 3'h0};
    always #4 clock = ~clock;
    cpu_register_core i_dut (.*);
    boot_rom_model i_rom (.*);
    // ----
    // Access tasks
    // ----
    task clr;
        {fetch_adv, branch_load, irq_ack, flag_word_save_op, sp_pop,
         flag_word_restore_op, break_return_op, irq_return_op, greg_wr,
         irq_block_op, irq_unblock_op, bank_choose_op, isp_load, sp_push,
         alu_update, carry_load, sp_load, mem_req} = '0;
    endtask
    task step;
        @(posedge clock);
        #1;
        clr;
        @(posedge clock);
        #1;
    endtask
    task chk(input string n, input logic [15:0] e, g);
        tests_run++;
        if (g !== e) begin
            errors++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task mem(input logic w, input logic [15:0] a, input logic [7:0] d);
        mem_req = 1;
        mem_wr = w;
        mem_addr = a;
        mem_wdata = d;
        step;
    endtask
    task tally_and_finish;
        if (errors == 0 && tests_run > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        #20000;
        errors++;
        tally_and_finish;
    end
    initial begin
        {isp_val, alu_nib_carry, carry_val, greg_wr_pair, mem_wr, mem_word,
         mem_fetch, irq_req_maskable, irq_req_low_prio, fetch_len,
         greg_rd_sel, greg_wr_sel, branch_target, sp_load_val, greg_wr_data,
         mem_addr, flag_word_pop_data, alu_result, mem_wdata,
         bank_choose_val, greg_pair_sel} = '0;
        clr;
        repeat (6) @(posedge clock);
        #1;
        chk("flag_word", 8'h02, processor_flag_word);
        chk("boot_busy", 1, boot_busy);
        chk("boot_addr", 16'h0000, boot_addr);
        sys_rst = 0;
        repeat (2) @(posedge clock);
        #1;
        chk("vector", 16'h1234, next_fetch_pointer);
        chk("boot_busy", 0, boot_busy);
        chk("boot_addr", 16'h0001, boot_addr);
        fetch_adv = 1;
        fetch_len = 3'h7;
        step;
        chk("fetch", 16'h123B, next_fetch_pointer);
        fetch_adv = 1;
        branch_load = 1;
        branch_target = 16'hF400;
        step;
        chk("branch", 16'hF400, next_fetch_pointer);
        sp_load = 1;
        sp_load_val = 16'hFB01;
        step;
        sp_push = 1;
        step;
        sp_push = 1;
        step;
        chk("sp_low", 16'hFAFF, stack_top_pointer);
        chk("sp_range", 1, sp_range_err);
        sp_pop = 1;
        step;
        sp_pop = 1;
        step;
        chk("sp_back", 16'hFB01, stack_top_pointer);
        chk("sp_range", 0, sp_range_err);
        irq_unblock_op = 1;
        irq_req_maskable = 1;
        irq_req_low_prio = 1;
        step;
        chk("accept", 1, irq_accept);
        isp_load = 1;
        step;
        chk("low_prio", 0, irq_accept);
        irq_req_low_prio = 0;
        step;
        chk("high_prio", 1, irq_accept);
        irq_ack = 1;
        step;
        chk("ack_flags", 8'h00, processor_flag_word);
        chk("ack_sp", 16'hFB00, stack_top_pointer);
        flag_word_save_op = 1;
        step;
        chk("save_sp", 16'hFAFF, stack_top_pointer);
        sp_load = 1;
        sp_push = 1;
        sp_load_val = 16'hFB10;
        step;
        chk("load_wins", 16'hFB10, stack_top_pointer);
        for (int i = 0; i < 3; i++) begin
            {irq_return_op, break_return_op,
             flag_word_restore_op} = 3'h1 << i;
            irq_unblock_op = 1;
            flag_word_pop_data = 8'h20 >> (2 * i);
            step;
            chk("pop", 8'h20 >> (2 * i), processor_flag_word);
        end
        irq_unblock_op = 1;
        step;
        chk("unblock", 8'h82, processor_flag_word);
        irq_block_op = 1;
        irq_unblock_op = 1;
        step;
        chk("block", 8'h02, processor_flag_word);
        alu_update = 1;
        alu_nib_carry = 1;
        carry_load = 1;
        carry_val = 1;
        step;
        chk("alu_set", 8'h53, processor_flag_word);
        alu_update = 1;
        alu_result = 8'h10;
        alu_nib_carry = 0;
        carry_load = 1;
        carry_val = 0;
        step;
        chk("alu_clr", 8'h02, processor_flag_word);
        for (int b = 0; b < 4; b++) begin
            logic [7:0] fx;
            bank_choose_op = 1;
            bank_choose_val = 2'(b);
            step;
            fx = {2'h0, b[1], 1'b0, b[0], 3'h2};
            chk("bank", fx, processor_flag_word);
            greg_wr = 1;
            greg_wr_pair = 1;
            greg_wr_sel = 3'h2;
            greg_wr_data = 16'hC0D0 | 16'(b);
            greg_pair_sel = 2'h1;
            greg_rd_sel = 3'h3;
            step;
            chk("pair", greg_wr_data, greg_rd_pair);
            chk("byte", 8'hC0, greg_rd_byte);
            mem(1'b0, 16'hFEE2 | 16'(b << 3), 8'h00);
            chk("greg_lo", 16'hD0 | 16'(b), mem_rdata);
        end
        greg_wr = 1;
        greg_wr_pair = 0;
        greg_wr_sel = 3'h5;
        greg_rd_sel = 3'h5;
        greg_wr_data = 16'h00A5;
        step;
        chk("byte_wr", 8'hA5, greg_rd_byte);
        mem(1'b0, 16'hFEFD, 8'h00);
        chk("byte_abs", 8'hA5, mem_rdata);
        for (int i = 0; i < 11; i++) begin
            logic [7:0] d;
            logic [7:0] x;
            d = ra[i][7:0] ^ 8'h5A;
            x = re[i] inside {3'h1, 3'h2, 3'h3} ? d : 8'h00;
            if (re[i] == 3'h4) x = {5'h00, d[2:0]};
            mem(1'b1, ra[i], d);
            mem(1'b0, ra[i], 8'h00);
            chk("region", re[i], mem_region);
            chk("rdata", x, mem_rdata);
        end
        mem_fetch = 1;
        mem(1'b0, 16'hFB00, 8'h00);
        chk("fetch_fast", 1, mem_fault);
        mem(1'b0, 16'hF400, 8'h00);
        chk("fetch_exp", 0, mem_fault);
        mem_fetch = 0;
        mem_word = 1;
        mem(1'b0, 16'hFF01, 8'h00);
        chk("odd_word", 1, mem_fault);
        mem(1'b0, 16'hFF02, 8'h00);
        chk("even_word", 0, mem_fault);
        tally_and_finish;
    end
endmodule
